// *** sdrci_pkg.sv ***
// Shared constants, command codes and carrier types of the command interface.
// Assumes one 100 MHz clock and pins already synchronous to it.
// How it works
// - Chip select high registers no command.
// - No-operation leaves running bursts untouched.
// - Mode load takes op-code from address 11:0.
// - Activate opens row until that bank precharged.
// - Column, bank, and auto precharge bit per access.
// - Auto precharge closes row when burst runs to its end.
// - Read mask high floats lanes two clocks later.
// - Write mask high drops that lane's data.
// - Precharge closes one bank, or all banks.
// - Burst terminate truncates latest burst, any bank.
// - Refresh with enable high auto, low self.
// - Auto refresh uses internal row counter only.
// - Self refresh ignores all but clock enable.
// - Strobe encodings select the eight commands.
package sdrci_pkg;
	////////////////////////////////////////////////////////////////////////
	// Geometry
	localparam int ROW_W = 13; // Row address width
	localparam int COL_W = 10; // Column address width
	localparam int BANK_W = 2; // Bank select width
	localparam int NBANK = 4; // Quad bank
	localparam int DQ_W = 16; // Data lane width
	localparam int DQM_W = 2; // One mask per byte lane
	localparam int MODE_W = 12; // Mode op-code width
	localparam int AP_BIT = 10; // Auto precharge address bit
	localparam int BURST_LEN = 4; // Default burst length in beats

	////////////////////////////////////////////////////////////////////////
	// Reset values and timing
	localparam logic [MODE_W-1:0] MODE_RST = 12'h000;
	localparam logic [ROW_W-1:0] REF_ROW_RST = 13'h0000;
	localparam int CLK_PERIOD_NS = 10; // 100 MHz clock
	localparam int SREF_INTERVAL_NS = 7813; // Internal refresh spacing
	// Longest time, so round down
	localparam int SREF_INTERVAL_CYC = SREF_INTERVAL_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Command codes: strobes {row, column, write-enable}, active low
	localparam logic [2:0] CODE_ACT = 3'h3;
	localparam logic [2:0] CODE_RD = 3'h5;
	localparam logic [2:0] CODE_WR = 3'h4;
	localparam logic [2:0] CODE_PRE = 3'h2;
	localparam logic [2:0] CODE_TERM = 3'h6;
	localparam logic [2:0] CODE_REF = 3'h1;
	localparam logic [2:0] CODE_MODE = 3'h0;
	localparam logic [2:0] CODE_NOP = 3'h7;

	typedef enum {SDRCI_NORMAL, SDRCI_SELF_REF} sdrci_state_t;

	// Pins sampled each rising edge
	typedef struct packed {
		logic cs_n; // Chip select, low selects
		logic ras_n; // Row strobe
		logic cas_n; // Column strobe
		logic we_n; // Write enable
		logic cke; // Clock enable
		logic bank_select_1; // Bank select high bit
		logic bank_select_0; // Bank select low bit
		logic [ROW_W-1:0] addr; // Address lines
	} sdrci_cmd_t;

	// One accepted write beat toward the array
	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [DQM_W-1:0] mask; // High lane is not written
		logic [DQ_W-1:0] data;
	} sdrci_wbeat_t;

	// Read beat address toward the array
	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
	} sdrci_raddr_t;
endpackage

// *** sdrci_top.sv ***
// Command decoder, bank tracker, burst engine and data lanes of the device.
// Assumes a synchronous array behind WB_* and RD_ADDR/RD_DATA (one cycle read).
`timescale 1ns/100ps
module sdrci_top #(
	parameter int SREF_CYC = sdrci_pkg::SREF_INTERVAL_CYC,
	parameter int BURST = sdrci_pkg::BURST_LEN
) (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire sdrci_pkg::sdrci_cmd_t CMD,
	input wire logic [sdrci_pkg::DQ_W-1:0] DQ_IN,
	input wire logic [sdrci_pkg::DQM_W-1:0] DQM,
	output logic [sdrci_pkg::DQ_W-1:0] DQ_OUT,
	output logic [sdrci_pkg::DQM_W-1:0] DQ_OE,
	output sdrci_pkg::sdrci_raddr_t RD_ADDR,
	output logic RD_VALID,
	input wire logic [sdrci_pkg::DQ_W-1:0] RD_DATA,
	output sdrci_pkg::sdrci_wbeat_t WB_WORD,
	output logic WB_VALID,
	input wire logic WB_READY,
	output logic [sdrci_pkg::NBANK-1:0] BANK_OPEN,
	output logic [sdrci_pkg::MODE_W-1:0] MODE_WORD,
	output logic [sdrci_pkg::ROW_W-1:0] REF_ROW,
	output logic REF_PULSE,
	output logic SELF_REF,
	output logic BURST_ACT,
	output logic OVERFLOW
);
	import sdrci_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Decode
	sdrci_state_t state_r; // Normal or self refresh
	wire in_self = (state_r == SDRCI_SELF_REF);
	wire [2:0] code = {CMD.ras_n, CMD.cas_n, CMD.we_n};
	// Deselect and self refresh both block every command
	wire sel = ~CMD.cs_n & CMD.cke & ~in_self;
	wire is_act = sel & (code == CODE_ACT);
	wire is_rd = sel & (code == CODE_RD);
	wire is_wr = sel & (code == CODE_WR);
	wire is_pre = sel & (code == CODE_PRE);
	wire is_term = sel & (code == CODE_TERM);
	wire is_mode = sel & (code == CODE_MODE);
	wire is_aref = sel & (code == CODE_REF);
	// Self refresh entry is the refresh code with enable low
	wire is_sref = ~CMD.cs_n & ~CMD.cke & ~in_self & (code == CODE_REF);
	wire [BANK_W-1:0] cmd_bank = {CMD.bank_select_1, CMD.bank_select_0};
	wire ap_bit = CMD.addr[AP_BIT]; // auto_precharge_bit

	////////////////////////////////////////////////////////////////////////
	// Burst engine state
	logic burst_r; // Burst running
	logic burst_wr_r; // Running burst is a write
	logic burst_ap_r; // Running burst closes its row
	logic [BANK_W-1:0] burst_bank_r;
	logic [COL_W-1:0] col_r; // Column of the next beat
	logic [7:0] left_r; // Beats still to come
	logic [ROW_W-1:0] open_row_r [NBANK]; // Row open per bank

	wire new_burst = is_rd | is_wr;
	// A new access or a terminate ends the running burst at once
	wire cont = burst_r & ~new_burst & ~is_term;
	wire beat = new_burst | cont;
	wire beat_wr = new_burst ? is_wr : burst_wr_r;
	wire [BANK_W-1:0] beat_bank = new_burst ? cmd_bank : burst_bank_r;
	wire [COL_W-1:0] beat_col = new_burst ? CMD.addr[COL_W-1:0] : col_r;
	wire [7:0] burst_m1 = 8'(BURST - 1);
	wire last_cont = cont & (left_r == 8'h01);
	wire single = new_burst & (burst_m1 == 8'h00);
	// Auto precharge of the burst that finishes normally this cycle
	wire ap_close = (last_cont & burst_ap_r) | (single & ap_bit);
	wire [BANK_W-1:0] ap_bank = new_burst ? cmd_bank : burst_bank_r;

	// Burst engine
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			burst_r <= 1'b0;
			burst_wr_r <= 1'b0;
			burst_ap_r <= 1'b0;
			burst_bank_r <= '0;
			col_r <= '0;
			left_r <= 8'h00;
		end else if (new_burst) begin
			burst_r <= (burst_m1 != 8'h00);
			burst_wr_r <= is_wr;
			burst_ap_r <= ap_bit;
			burst_bank_r <= cmd_bank;
			col_r <= COL_W'(CMD.addr[COL_W-1:0] + 1'b1);
			left_r <= burst_m1;
		end else if (cont) begin
			burst_r <= ~last_cont;
			col_r <= COL_W'(col_r + 1'b1);
			left_r <= 8'(left_r - 1'b1);
		end else begin
			// Terminate, or nothing running
			burst_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-bank open flag and row
	logic [NBANK-1:0] open_r;
	genvar gb;
	generate
		for (gb = 0; gb < NBANK; gb++) begin : g_bank
			wire hit = (cmd_bank == BANK_W'(gb));
			wire pre_me = is_pre & (ap_bit | hit);
			wire ap_me = ap_close & (ap_bank == BANK_W'(gb));
			// Row stays open until closed here
			always_ff @(posedge SYS_CLK) begin
				if (SRST) begin
					open_r[gb] <= 1'b0;
					open_row_r[gb] <= '0;
				end else if (is_act & hit) begin
					open_r[gb] <= 1'b1;
					open_row_r[gb] <= CMD.addr;
				end else if (pre_me | ap_me) begin
					open_r[gb] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Mode register, refresh counter, self refresh
	logic [MODE_W-1:0] mode_r;
	logic [ROW_W-1:0] ref_row_r;
	logic ref_pulse_r;
	logic [15:0] sref_cnt_r; // Internal refresh timer
	wire sref_tick = in_self & (sref_cnt_r == 16'(SREF_CYC - 1));
	wire ref_step = is_aref | sref_tick;

	// Mode load and refresh bookkeeping
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			mode_r <= MODE_RST;
			ref_row_r <= REF_ROW_RST;
			ref_pulse_r <= 1'b0;
		end else begin
			if (is_mode) begin
				mode_r <= CMD.addr[MODE_W-1:0];
			end
			if (ref_step) begin
				ref_row_r <= ROW_W'(ref_row_r + 1'b1);
			end
			ref_pulse_r <= ref_step;
		end
	end

	// Self refresh entry and exit; exit on enable high
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_r <= SDRCI_NORMAL;
			sref_cnt_r <= 16'h0000;
		end else begin
			case (state_r)
				SDRCI_NORMAL: begin
					sref_cnt_r <= 16'h0000;
					if (is_sref) begin
						state_r <= SDRCI_SELF_REF;
					end
				end
				SDRCI_SELF_REF: begin
					sref_cnt_r <= sref_tick ? 16'h0000 : 16'(sref_cnt_r + 1'b1);
					if (CMD.cke) begin
						state_r <= SDRCI_NORMAL;
					end
				end
				default: state_r <= SDRCI_NORMAL;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read lanes: mask sampled now governs the lanes two edges on
	logic rd_p1_r;
	logic [DQM_W-1:0] dqm_p1_r;
	logic rd_valid_r;
	sdrci_raddr_t raddr_r;
	logic [DQ_W-1:0] dq_out_r;
	logic [DQM_W-1:0] dq_oe_r;

	// Read address, mask pipe, lane enables
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			rd_p1_r <= 1'b0;
			dqm_p1_r <= '0;
			rd_valid_r <= 1'b0;
			raddr_r <= '0;
			dq_out_r <= '0;
			dq_oe_r <= '0;
		end else begin
			rd_valid_r <= beat & ~beat_wr;
			raddr_r <= '{bank: beat_bank, row: open_row_r[beat_bank], col: beat_col};
			rd_p1_r <= rd_valid_r;
			dqm_p1_r <= DQM;
			dq_out_r <= RD_DATA;
			// Gate with the beat whose data enters dq_out_r at this same edge
			dq_oe_r <= rd_p1_r ? ~dqm_p1_r : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Two-entry write buffer; data taken in the command cycle
	sdrci_wbeat_t buf_r [2];
	logic [1:0] cnt_r; // Entries held
	logic rp_r; // Read slot
	logic wp_r; // Write slot
	logic ovf_r;
	// A beat with every lane masked writes nothing and is not queued
	wire push_req = beat & beat_wr & ~(&DQM);
	wire full = (cnt_r == 2'd2);
	wire push = push_req & ~full;
	wire pop = WB_VALID & WB_READY;
	sdrci_wbeat_t wb_in;
	assign wb_in = '{bank: beat_bank, row: open_row_r[beat_bank], col: beat_col,
		mask: DQM, data: DQ_IN};

	// Buffer storage and pointers
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			cnt_r <= 2'd0;
			rp_r <= 1'b0;
			wp_r <= 1'b0;
			ovf_r <= 1'b0;
		end else begin
			if (push) begin
				buf_r[wp_r] <= wb_in;
				wp_r <= ~wp_r;
			end
			if (pop) begin
				rp_r <= ~rp_r;
			end
			cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
			// Sticky: a beat refused by a full buffer is lost
			ovf_r <= ovf_r | (push_req & full);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output registers
	logic wb_valid_r;
	sdrci_wbeat_t wb_word_r;
	// Head of buffer, re-registered; next head chosen ahead of pop
	wire [1:0] cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
	wire rp_nxt = pop ? ~rp_r : rp_r;
	wire head_from_in = (cnt_r == 2'd0) | ((cnt_r == 2'd1) & pop);
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			wb_valid_r <= 1'b0;
			wb_word_r <= '0;
		end else begin
			wb_valid_r <= (cnt_nxt != 2'd0);
			wb_word_r <= head_from_in ? wb_in : buf_r[rp_nxt];
		end
	end

	assign WB_VALID = wb_valid_r;
	assign WB_WORD = wb_word_r;
	assign DQ_OUT = dq_out_r;
	assign DQ_OE = dq_oe_r;
	assign RD_ADDR = raddr_r;
	assign RD_VALID = rd_valid_r;
	assign BANK_OPEN = open_r;
	assign MODE_WORD = mode_r;
	assign REF_ROW = ref_row_r;
	assign REF_PULSE = ref_pulse_r;
	assign SELF_REF = in_self;
	assign BURST_ACT = burst_r;
	assign OVERFLOW = ovf_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_deselect_no_act: assert property (@(posedge SYS_CLK) disable iff (SRST)
		CMD.cs_n && !ap_close |=> $stable(open_r))
		else $error("bank state changed while deselected");
	a_nop_keeps_burst: assert property (@(posedge SYS_CLK) disable iff (SRST)
		burst_r && left_r > 8'h01 && (CMD.cs_n || code == CODE_NOP) |=> burst_r)
		else $error("burst stopped by idle cycle");
	a_mode_load_word: assert property (@(posedge SYS_CLK) disable iff (SRST)
		is_mode |=> MODE_WORD == $past(CMD.addr[MODE_W-1:0]))
		else $error("mode word not loaded");
	a_act_opens_bank: assert property (@(posedge SYS_CLK) disable iff (SRST)
		is_act |=> BANK_OPEN[$past(cmd_bank)])
		else $error("activate did not open bank");
	a_pre_all_close: assert property (@(posedge SYS_CLK) disable iff (SRST)
		is_pre && ap_bit |=> BANK_OPEN == '0)
		else $error("precharge all left a bank open");
	a_term_stops_burst: assert property (@(posedge SYS_CLK) disable iff (SRST)
		is_term |=> !burst_r ##1 (!rd_valid_r || $past(new_burst)))
		else $error("terminate did not stop burst");
	a_read_mask_float: assert property (@(posedge SYS_CLK) disable iff (SRST)
		DQM[0] && !SRST ##1 !SRST |=> !DQ_OE[0])
		else $error("masked read lane driven");
	a_sref_enter: assert property (@(posedge SYS_CLK) disable iff (SRST)
		is_sref |=> SELF_REF)
		else $error("self refresh not entered");
	a_sref_ignores: assert property (@(posedge SYS_CLK) disable iff (SRST)
		in_self |=> $stable(MODE_WORD) && $stable(BANK_OPEN))
		else $error("command taken in self refresh");
	a_ap_closes: assert property (@(posedge SYS_CLK) disable iff (SRST)
		ap_close && !is_act |=> !BANK_OPEN[$past(ap_bank)])
		else $error("auto precharge left row open");
	a_wmask_skip: assert property (@(posedge SYS_CLK) disable iff (SRST)
		beat && beat_wr && (&DQM) && !pop |=> cnt_r == $past(cnt_r))
		else $error("fully masked write queued");
	a_aref_counts: assert property (@(posedge SYS_CLK) disable iff (SRST)
		is_aref |=> REF_ROW == ROW_W'($past(REF_ROW) + 1'b1) && REF_PULSE)
		else $error("refresh row not advanced");
endmodule

// *** sdrci_array_model.sv ***
// Behavioural memory array that sits behind the read and write beat ports.
// Assumes one shared clock; unwritten locations read as BLANK.
`timescale 1ns/100ps
module sdrci_array_model #(
	parameter logic [15:0] BLANK = 16'h5a5a
) (
	input wire logic clk,
	input wire logic stall,
	input wire sdrci_pkg::sdrci_raddr_t rd_addr,
	input wire logic rd_valid,
	output logic [15:0] rd_data,
	input wire sdrci_pkg::sdrci_wbeat_t wb_word,
	input wire logic wb_valid,
	output logic wb_ready
);
	import sdrci_pkg::*;
	////////////////////////////////////////////////////////////////////////
	logic [15:0] mem [bit [24:0]]; // Sparse array keyed by bank, row, col
	logic [15:0] old; // Prior content of the written word
	int n_pops = 0; // Accepted write beats
	initial rd_data = 16'h0000;
	assign wb_ready = !stall; // Stall holds the buffer's output
	// Read answers one cycle after the request, write pops on handshake
	always @(posedge clk) begin
		if (rd_valid) begin
			rd_data <= mem.exists(rd_addr) ? mem[rd_addr] : BLANK;
		end else begin
			rd_data <= ~rd_data; // No stale word outside a beat
		end
		if (wb_valid && wb_ready) begin
			old = mem.exists({wb_word.bank, wb_word.row, wb_word.col}) ?
				mem[{wb_word.bank, wb_word.row, wb_word.col}] : BLANK;
			// Masked lanes keep the old byte
			mem[{wb_word.bank, wb_word.row, wb_word.col}] = {
				wb_word.mask[1] ? old[15:8] : wb_word.data[15:8],
				wb_word.mask[0] ? old[7:0] : wb_word.data[7:0]};
			n_pops++;
		end
	end
endmodule

// *** sdrci_top_test.sv ***
// Self-checking bench of the command interface with its array model.
// Assumes the device resets to all-zero outputs and BURST of 4.
`timescale 1ns/100ps
module sdrci_top_test;
	import sdrci_pkg::*;
	////////////////////////////////////////////////////////////////////////
	logic sys_clk = 0;
	logic srst = 1;
	sdrci_cmd_t cmd;
	logic [15:0] dq_in, dq_out, rd_data;
	logic [1:0] dqm, dq_oe;
	logic stall, rd_valid, wb_valid, wb_ready, ref_pulse, self_ref, burst_act, overflow;
	sdrci_raddr_t rd_addr;
	sdrci_wbeat_t wb_word;
	logic [3:0] bank_open;
	logic [11:0] mode_word;
	logic [12:0] ref_row;
	int mismatches = 0;
	int n_compared = 0;
	localparam int PRECHARGE_PERIOD_CYC = 2; // Whole clocks
	localparam int SELF_REFRESH_EXIT_CYC = 2; // Whole clocks
	always #5 sys_clk = ~sys_clk; // 100 MHz
	sdrci_top #(.SREF_CYC(8), .BURST(4)) sdrci_top_i (.SYS_CLK(sys_clk), .SRST(srst),
		.CMD(cmd), .DQ_IN(dq_in), .DQM(dqm), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
		.RD_ADDR(rd_addr), .RD_VALID(rd_valid), .RD_DATA(rd_data), .WB_WORD(wb_word),
		.WB_VALID(wb_valid), .WB_READY(wb_ready), .BANK_OPEN(bank_open),
		.MODE_WORD(mode_word), .REF_ROW(ref_row), .REF_PULSE(ref_pulse),
		.SELF_REF(self_ref), .BURST_ACT(burst_act), .OVERFLOW(overflow));
	sdrci_array_model sdrci_array_model_i (.clk(sys_clk), .stall(stall), .rd_addr(rd_addr),
		.rd_valid(rd_valid), .rd_data(rd_data), .wb_word(wb_word), .wb_valid(wb_valid),
		.wb_ready(wb_ready));
	////////////////////////////////////////////////////////////////////////
	// Compare one value, count and report
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Drive one command at the falling edge; clock enable high unless asked
	task issue(input logic [2:0] code, input logic [1:0] ba, input logic [12:0] a,
		input logic ke = 1'b1, input logic cs = 1'b0);
		@(negedge sys_clk);
		cmd = {cs, code, ke, ba, a};
	endtask
	task nop(input int n);
		repeat (n) issue(CODE_NOP, 2'h0, 13'h0000);
	endtask
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Mode load with banks idle; deselected load must not land
	task t_mode;
		issue(CODE_MODE, 2'h0, 13'h0555, 1'b1, 1'b1);
		nop(1);
		check("mode_desel", mode_word, 12'h000);
		issue(CODE_MODE, 2'h3, 13'h1abc);
		nop(1);
		check("mode_word", mode_word, 12'habc);
		nop(2);
		check("mode_hold", mode_word, 12'habc);
		$display("mode test done");
	endtask
	// Open three banks, close one, then all with bank inputs set
	task t_bank;
		issue(CODE_ACT, 2'h0, 13'h0003);
		issue(CODE_ACT, 2'h2, 13'h0004);
		issue(CODE_ACT, 2'h3, 13'h0005);
		nop(1);
		check("open3", bank_open, 4'b1101);
		issue(CODE_PRE, 2'h2, 13'h0000);
		nop(1);
		check("pre_one", bank_open, 4'b1001);
		issue(CODE_ACT, 2'h1, 13'h0006, 1'b1, 1'b1);
		nop(1);
		check("act_desel", bank_open, 4'b1001);
		issue(CODE_PRE, 2'h2, 13'h0400);
		nop(1);
		check("pre_all", bank_open, 4'b0000);
		$display("bank test done");
	endtask
	// Masked write burst then auto-precharge read of the same columns
	task t_wr_rd;
		logic [7:0] wm;
		logic [1:0] pat [8];
		logic [15:0] rexp [4];
		int p0;
		wm = 8'b10_01_11_00;
		pat = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b10, 2'b11, 2'b00, 2'b00};
		rexp = '{16'ha5c0, 16'h5a5a, 16'ha55a, 16'h5ac3};
		issue(CODE_ACT, 2'h1, 13'h0005);
		p0 = sdrci_array_model_i.n_pops;
		for (int i = 0; i < 4; i++) begin
			issue(i == 0 ? CODE_WR : CODE_NOP, 2'h1, 13'h0000);
			dq_in = 16'ha5c0 | 16'(i);
			dqm = wm[2*i+:2];
		end
		nop(5);
		dqm = 2'b00;
		check("wr_pops", sdrci_array_model_i.n_pops - p0, 3);
		issue(CODE_RD, 2'h1, 13'h0400);
		for (int i = 1; i < 8; i++) begin
			issue(CODE_NOP, 2'h0, 13'h0000);
			dqm = pat[i];
			if (i >= 1 && i <= 4) begin
				check("rd_valid", rd_valid, 1);
				check("rd_addr", rd_addr, {2'h1, 13'h0005, 10'(i-1)});
			end else
				check("rd_end", rd_valid, 0);
			if (i >= 3 && i <= 6)
				check("dq_oe", dq_oe, 2'(~pat[i-2]));
			else if (i == 7)
				check("dq_oe_end", dq_oe, 0);
			if (i >= 3 && i <= 6)
				check("dq_out", dq_out, rexp[i-3]);
			if (i == 3)
				check("ap_open", bank_open[1], 1);
			if (i == 4)
				check("ap_closed", bank_open[1], 0);
		end
		$display("write read test done");
	endtask
	// Terminate a write after two beats, from another bank's view
	task t_term;
		int p0;
		issue(CODE_ACT, 2'h1, 13'h0005);
		p0 = sdrci_array_model_i.n_pops;
		issue(CODE_WR, 2'h1, 13'h0008);
		issue(CODE_NOP, 2'h0, 13'h0000);
		issue(CODE_TERM, 2'h3, 13'h0000);
		nop(1);
		check("term_burst", burst_act, 0);
		nop(4);
		check("term_pops", sdrci_array_model_i.n_pops - p0, 2);
		check("no_ap_open", bank_open[1], 1);
		$display("terminate test done");
	endtask
	// Auto refresh, then self refresh with ignored traffic and exit
	task t_refresh;
		int n;
		n = 0;
		issue(CODE_PRE, 2'h0, 13'h0400);
		nop(PRECHARGE_PERIOD_CYC);
		issue(CODE_REF, 2'h3, 13'h1fff);
		nop(1);
		check("ref_row", ref_row, 13'h0001);
		check("ref_pulse", ref_pulse, 1);
		nop(1);
		check("pulse_end", ref_pulse, 0);
		issue(CODE_REF, 2'h0, 13'h0000, 1'b0);
		for (int i = 0; i < 20; i++) begin
			issue(CODE_MODE, 2'h0, 13'h0fff, 1'b0);
			n += ref_pulse;
		end
		check("self_ref", self_ref, 1);
		check("self_pulses", n, 2);
		check("self_row", ref_row, 13'h0003);
		// Enable high is seen with the first no-op, so look one edge later
		nop(SELF_REFRESH_EXIT_CYC);
		check("self_exit", self_ref, 0);
		issue(CODE_REF, 2'h0, 13'h0000);
		nop(1);
		check("exit_ref", ref_row, 13'h0004);
		nop(2);
		check("self_mode", mode_word, 12'habc);
		$display("refresh test done");
	endtask
	// Stalled receiver: two beats held, later ones dropped and flagged
	task t_overflow;
		int p0;
		stall = 1;
		issue(CODE_ACT, 2'h2, 13'h0007);
		p0 = sdrci_array_model_i.n_pops;
		for (int i = 0; i < 4; i++) begin
			issue(i == 0 ? CODE_WR : CODE_NOP, 2'h2, 13'h0000);
			dq_in = 16'h0f00 | 16'(i);
		end
		nop(3);
		check("overflow", overflow, 1);
		check("wb_valid", wb_valid, 1);
		check("wb_data", wb_word.data, 16'h0f00);
		stall = 0;
		nop(4);
		check("ovf_pops", sdrci_array_model_i.n_pops - p0, 2);
		srst = 1;
		nop(2);
		srst = 0;
		nop(1);
		check("ovf_clear", overflow, 0);
		check("rst_banks", bank_open, 4'b0000);
		$display("overflow test done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence after a 16-cycle reset
	initial begin
		cmd = {1'b1, CODE_NOP, 1'b1, 2'h0, 13'h0000};
		dq_in = 16'h0000;
		dqm = 2'b00;
		stall = 0;
		repeat (16) @(negedge sys_clk);
		srst = 0;
		nop(1);
		check("rst_mode", mode_word, 12'h000);
		check("rst_row", ref_row, 13'h0000);
		t_mode();
		t_bank();
		t_wr_rd();
		t_term();
		t_refresh();
		t_overflow();
		complete_run();
	end
	// Watchdog, far beyond the hundred or so cycles the tests take
	initial begin
		#100000;
		mismatches++;
		complete_run();
	end
endmodule
